// >>> include/asq_pkg.sv
// Purpose: shared constants and types of the serial conversion sequencer
// Assumes: one 16-edge conversion per group of serial clock edges
// Notes: the channel field sits in bits 5..3 of the control byte
package asq_pkg;

  localparam int CONV_EDGES = 16;
  localparam int CTRL_BITS = 8;
  localparam int RESULT_BITS = 10;
  localparam int CHAN_BITS = 3;

  // control byte field positions
  localparam int CHAN_MSB_POS = 5;
  localparam int CHAN_LSB_POS = 3;

  // edge counter values, counted from zero (rising edges seen so far)
  localparam logic [3:0] CNT_TRACK_LAST = 4'h2;
  localparam logic [3:0] CNT_MSB_SLOT = 4'h4;
  localparam logic [3:0] CNT_LSB_SLOT = 4'hD;
  localparam logic [3:0] CNT_CTRL_LAST = 4'h7;
  localparam logic [3:0] CNT_LAST = 4'hF;

  // reset values
  localparam logic [2:0] CHAN_RESET = 3'h0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [9:0] CODE_RESET = 10'h000;
  localparam logic [3:0] CNT_RESET = 4'h0;

  typedef enum logic [1:0] {
    ASQ_TRACK = 2'b00,
    ASQ_HOLD = 2'b01,
    ASQ_DOWN = 2'b10
  } asq_phase_t;

  typedef struct packed {
    logic [2:0] chan;
    logic [9:0] code;
  } asq_result_t;

endpackage

// >>> tb/asq_host.sv
// Purpose: host serial controller model driving frames
// Assumes: 80 ns serial clock, runs two periods after each frame, then stands still
// Notes: released din toggles so stale values are never read
`timescale 1ns/1ps
module asq_host (
  output logic sclk,
  output logic csN,
  output logic din,
  input wire logic doutO
);
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    din = 1'b0;
  end
  // low idle clock makes the select fall count as edge one
  task open(input logic hi);
    sclk = hi;
    #13 csN = 1'b0;
  endtask
  task cyc(input int n, input logic [7:0] ctl, output logic [15:0] sh);
    for (int i = 0; i < n; i++) begin
      if (sclk) #40 sclk = 1'b0;
      din = (i < 8) ? ctl[7-i] : ~din;
      #40 sclk = 1'b1;
      sh = {sh[14:0], doutO};
    end
  endtask
  task close;
    #20 csN = 1'b1;
    din = ~din;
    repeat (4) #40 sclk = ~sclk;
  endtask
endmodule

// >>> tb/asq_sequencer_chk.sv
// Purpose: port-level checks of the conversion sequencer
// Assumes: bound to asq_sequencer, link checks sample on sclk
// Notes: link checks rest while the frame is closed, except gate_off_a
`timescale 1ns/1ps
module asq_chk
  import asq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sclk,
  input wire logic csN,
  input wire logic din,
  input wire logic [RESULT_BITS-1:0] sarResult,
  input wire logic doutO,
  input wire logic doutOe,
  input wire logic trackMode,
  input wire logic powerDown,
  input wire logic [CHAN_BITS-1:0] chanSel,
  input wire logic sysFrameActive,
  input wire asq_result_t sysResult,
  input wire logic sysResultValid
);
  sequence trackThenHold;
    trackMode [*3] ##1 !trackMode;
  endsequence
  oe_follow_a: assert property (@(posedge clk_sys) doutOe == !csN)
    else $error("output enable differs from frame select");
  idle_quiet_a: assert property (@(posedge clk_sys)
    csN |-> powerDown && !trackMode) else $error("awake outside a frame");
  gate_off_a: assert property (@(posedge sclk) disable iff (rst)
    csN |=> $stable(chanSel)) else $error("channel moved outside a frame");
  track_len_a: assert property (@(negedge sclk) disable iff (rst || csN)
    $rose(trackMode) |-> trackThenHold) else $error("track length wrong");
  down_brief_a: assert property (@(negedge sclk) disable iff (rst || csN)
    $rose(powerDown) |=> !powerDown) else $error("power-down too long");
  zeros_a: assert property (@(negedge sclk) disable iff (rst || csN)
    trackMode || powerDown |-> !doutO) else $error("padding bit not zero");
  // channel loads on rise 16 while still powered down; seen one rise later
  chan_late_a: assert property (@(posedge sclk) disable iff (rst || csN)
    !$stable(chanSel) |-> $past(powerDown))
    else $error("channel changed mid-conversion");
  power_wake_a: assert property (@(negedge sclk) disable iff (rst || csN)
    !$past(csN) && $fell(powerDown) |-> trackMode) else $error("wake without track");
  valid_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
    sysResultValid |=> !sysResultValid) else $error("result valid too long");
endmodule
bind asq_sequencer asq_chk chk (.*);

// >>> tb/tb.sv
// Purpose: self-checking bench of the conversion sequencer
// Assumes: host model paces the link, bench feeds the code
// Notes: channel used lags the byte by one conversion
`timescale 1ns/1ps
module tb;
  import asq_pkg::*;
  logic clk_sys, rst, sclk, csN, din, doutO, doutOe, trackMode, powerDown;
  logic sysFrameActive, sysResultValid;
  logic [RESULT_BITS-1:0] sarResult;
  logic [CHAN_BITS-1:0] chanSel, prev;
  asq_result_t sysResult;
  logic [15:0] got;
  int n_fail = 0;
  int checks = 0;
  `define CHK(a, e) begin \
    checks++; \
    if ((a) !== (e)) begin \
      n_fail++; \
      $display("mismatch at %0t: %0h vs %0h", $time, a, e); \
    end \
  end
  asq_sequencer dut (.*);
  asq_host host (.sclk(sclk), .csN(csN), .din(din), .doutO(doutO));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task test_done;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ignored bits carry the inverse of the channel
  task conv(input logic [2:0] ch, input logic [9:0] code);
    @(posedge clk_sys) sarResult <= code;
    host.cyc(16, {~ch[1:0], ch, ~ch}, got);
    #2;
    `CHK(got, {4'h0, code, 2'h0})
    `CHK(sysResult, {prev, code})
    `CHK(chanSel, ch)
    prev = ch;
  endtask
  initial begin
    rst = 1'b1;
    sarResult = CODE_RESET;
    prev = CHAN_RESET;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    #30 host.open(1'b1);
    #2 `CHK(trackMode, 1'b0)
    #25 `CHK(sysFrameActive, 1'b1)
    for (int c = 0; c < 9; c++) begin
      conv(3'(c), 10'h2A5 ^ 10'(c * 7));
    end
    host.close();
    `CHK(doutOe, 1'b0)
    `CHK(powerDown, 1'b1)
    host.open(1'b0);
    #2 `CHK(trackMode, 1'b1)
    `CHK(doutOe, 1'b1)
    host.cyc(5, 8'h38, got);
    host.close();
    `CHK(chanSel, prev)
    host.open(1'b0);
    conv(3'h5, 10'h3FF);
    conv(3'h2, 10'h001);
    host.close();
    #30 `CHK(sysFrameActive, 1'b0)
    test_done();
  end
  initial begin
    #60000;
    n_fail++;
    test_done();
  end
endmodule

// >>> verilog/asq_sequencer.sv
// Purpose: serial front end and conversion sequencer of the converter
// Assumes: sclk is the link clock; csN is low while a frame is open
// Notes: link counter, shifters and phase are held cleared while csN is high
// Function
// - track three cycles, then hold twelve cycles
// - serial output driven only while csN low
// - clock edges ignored while csN high
// - four zeros, ten result bits, two zeros
// - each new group restarts tracking, then hold
// - csN falls, sclk high: track at fall
// - csN falls, sclk low: track at once
// - simultaneous falls: track at once
// - control byte captured on first eight rises
// - bits 5..3 pick channel for next conversion
// - other control bits are ignored
// - channel zero after power-up
// - result is straight 10-bit binary code
// - powered down while csN high, after edge 16
`timescale 1ns/1ps
module asq_sequencer (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sclk,
  input wire logic csN,
  input wire logic din,
  input wire logic [asq_pkg::RESULT_BITS-1:0] sarResult,
  output logic doutO,
  output logic doutOe,
  output logic trackMode,
  output logic powerDown,
  output logic [asq_pkg::CHAN_BITS-1:0] chanSel,
  output logic sysFrameActive,
  output asq_pkg::asq_result_t sysResult,
  output logic sysResultValid
);
  import asq_pkg::*;

  logic linkRst;
  logic [3:0] riseCnt_r;
  logic [CTRL_BITS-1:0] ctrlShift_r;
  logic [CHAN_BITS-1:0] chanSel_r;
  asq_phase_t phase_r;
  asq_phase_t phase_nxt;
  logic dout_r;
  logic [RESULT_BITS-1:0] resShift_r;
  logic [RESULT_BITS-1:0] codeCap_r;
  logic waitFall_r;
  logic fellOnce_r;
  logic waiting;
  asq_result_t resultHold_r;
  logic resToggle_r;
  logic tSync1_r;
  logic tSync2_r;
  logic tSync3_r;
  logic csSync1_r;
  logic csSync2_r;
  logic csSync3_r;
  logic sysFrameActive_r;
  asq_result_t sysResult_r;
  logic sysResultValid_r;

  // frame select high clears the counter, shifter, output and phase flops: no edge outside a frame
  // advances anything, and a short frame is simply dropped
  assign linkRst = rst | csN;

  // ---------------- link domain, rising edges ----------------

  // rising edges counted modulo one conversion
  always_ff @(posedge sclk or posedge linkRst) begin
    if (linkRst) begin
      riseCnt_r <= CNT_RESET;
    end else begin
      riseCnt_r <= riseCnt_r + 4'h1;
    end
  end

  // control byte shifted in msb first on the first eight rises
  always_ff @(posedge sclk or posedge linkRst) begin
    if (linkRst) begin
      ctrlShift_r <= CTRL_RESET;
    end else if (riseCnt_r <= CNT_CTRL_LAST) begin
      ctrlShift_r <= {ctrlShift_r[CTRL_BITS-2:0], din};
    end
  end

  // channel survives frame ends; only a completed conversion updates it,
  // and only on its last rise so the running conversion keeps its input
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      chanSel_r <= CHAN_RESET;
    end else if (!csN && riseCnt_r == CNT_LAST) begin
      // remaining byte bits are dropped here
      chanSel_r <= ctrlShift_r[CHAN_MSB_POS:CHAN_LSB_POS];
    end
  end

  // ---------------- link domain, falling edges ----------------

  // sclk level at the frame-select fall: high means wait for a fall
  always_ff @(negedge csN or posedge rst) begin
    if (rst) begin
      waitFall_r <= 1'b0;
    end else begin
      waitFall_r <= sclk;
    end
  end

  always_ff @(negedge sclk or posedge linkRst) begin
    if (linkRst) begin
      fellOnce_r <= 1'b0;
    end else begin
      fellOnce_r <= 1'b1;
    end
  end

  assign waiting = waitFall_r & ~fellOnce_r;

  // the falling edge number is one above the rises already seen, so a
  // frame opened with sclk low counts its own fall as edge one
  always_comb begin
    if (riseCnt_r <= CNT_TRACK_LAST) begin
      phase_nxt = ASQ_TRACK;
    end else if (riseCnt_r == CNT_LAST) begin
      phase_nxt = ASQ_DOWN;
    end else begin
      phase_nxt = ASQ_HOLD;
    end
  end

  always_ff @(negedge sclk or posedge linkRst) begin
    if (linkRst) begin
      phase_r <= ASQ_TRACK;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // output slots: zeros, result msb first, zeros
  always_ff @(negedge sclk or posedge linkRst) begin
    if (linkRst) begin
      dout_r <= 1'b0;
      resShift_r <= CODE_RESET;
    end else begin
      case (riseCnt_r)
        CNT_MSB_SLOT: begin
          dout_r <= sarResult[RESULT_BITS-1];
          resShift_r <= {sarResult[RESULT_BITS-2:0], 1'b0};
        end
        default: begin
          if (riseCnt_r > CNT_MSB_SLOT && riseCnt_r <= CNT_LSB_SLOT) begin
            dout_r <= resShift_r[RESULT_BITS-1];
            resShift_r <= {resShift_r[RESULT_BITS-2:0], 1'b0};
          end else begin
            dout_r <= 1'b0;
          end
        end
      endcase
    end
  end

  // code kept whole for the system side; the shifter destroys its copy
  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      codeCap_r <= CODE_RESET;
    end else if (!csN && riseCnt_r == CNT_MSB_SLOT) begin
      codeCap_r <= sarResult;
    end
  end

  // finished conversions hand over by toggle; data then stands for at
  // least a whole conversion, far longer than the crossing needs
  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      resultHold_r <= '0;
      resToggle_r <= 1'b0;
    end else if (!csN && riseCnt_r == CNT_LAST) begin
      resultHold_r.chan <= chanSel_r;
      resultHold_r.code <= codeCap_r;
      resToggle_r <= ~resToggle_r;
    end
  end

  // pin-facing outputs except chanSel follow csN without a clock edge by nature
  assign doutO = dout_r;
  assign doutOe = ~csN;
  assign trackMode = ~csN & (phase_r == ASQ_TRACK) & ~waiting;
  assign powerDown = csN | (phase_r == ASQ_DOWN);
  assign chanSel = chanSel_r;

  // ---------------- system domain ----------------

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      csSync1_r <= 1'b1;
      csSync2_r <= 1'b1;
      csSync3_r <= 1'b1;
    end else begin
      csSync1_r <= csN;
      csSync2_r <= csSync1_r;
      csSync3_r <= csSync2_r;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sysFrameActive_r <= 1'b0;
    end else if (csSync2_r == csSync3_r) begin
      sysFrameActive_r <= ~csSync3_r;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tSync1_r <= 1'b0;
      tSync2_r <= 1'b0;
      tSync3_r <= 1'b0;
    end else begin
      tSync1_r <= resToggle_r;
      tSync2_r <= tSync1_r;
      tSync3_r <= tSync2_r;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sysResult_r <= '0;
      sysResultValid_r <= 1'b0;
    end else begin
      sysResultValid_r <= tSync2_r ^ tSync3_r;
      if (tSync2_r ^ tSync3_r) begin
        sysResult_r <= resultHold_r;
      end
    end
  end

  assign sysFrameActive = sysFrameActive_r;
  assign sysResult = sysResult_r;
  assign sysResultValid = sysResultValid_r;

endmodule
